//--- bench/udp_dma_ctrl_monitor.sv
`timescale 1ns/1ps
module udp_dma_ctrl_monitor
    import udp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_device_mode,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic o_avs_waitrequest,
    input wire logic o_phy_suspend,
    input wire logic [FIFO_N-1:0] o_fifo_sel,
    input wire logic o_fifo_rd,
    input wire logic [FIFO_N-1:0] o_fifo_flush,
    input wire logic o_mem_req,
    input wire logic o_mem_write,
    input wire logic [31:0] o_mem_addr,
    input wire logic o_mem_seq,
    input wire logic o_mem_undef_burst,
    input wire logic [3:0] o_mem_hprot,
    input wire logic i_mem_ready
);
    logic pw;
    logic [3:0] hp_r;
    logic ub_r;
    logic [7:0] bc_r;
    // only full-word writes are mirrored; partial writes leave the mirror stale
    assign pw = i_avs_write && !o_avs_waitrequest && i_avs_address == OFS_PARAM1
        && i_avs_byteenable == 4'hf;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hp_r <= RST_HPROT;
            ub_r <= RST_BURST;
        end else if (pw) begin
            hp_r <= i_avs_writedata[B_HPROT_LO+3:B_HPROT_LO];
            ub_r <= i_avs_writedata[B_BURST];
        end
    end
    // beats already finished in the running burst
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bc_r <= 8'h00;
        end else if (o_mem_req && i_mem_ready) begin
            bc_r <= o_mem_seq ? bc_r + 8'h01 : 8'h01;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////////
    reset_values_a: assert property ($fell(i_rst) |-> o_mem_undef_burst && !o_phy_suspend
        && o_mem_hprot == RST_HPROT && !o_mem_req) else $error("reset values wrong");
    suspend_gated_a: assert property (!i_device_mode |=> !o_phy_suspend)
        else $error("suspend outside device mode");
    attr_follow_a: assert property (pw |-> ##[1:2] (o_mem_hprot == hp_r
        && o_mem_undef_burst == ub_r)) else $error("bus attributes not from register");
    short_burst_a: assert property (o_mem_req && o_mem_seq && !o_mem_undef_burst
        |-> bc_r < 8'h04) else $error("burst longer than four beats");
    req_hold_a: assert property (o_mem_req && !i_mem_ready |=> o_mem_req
        && $stable(o_mem_addr) && $stable(o_mem_write)) else $error("request dropped");
    pop_pairs_a: assert property (o_fifo_rd |-> o_mem_req && o_mem_write)
        else $error("pop without memory write");
    flush_pulse_a: assert property (o_fifo_flush != 5'h00 |->
        (o_fifo_flush & ~o_fifo_sel) == 5'h00 ##1 o_fifo_flush == 5'h00)
        else $error("flush not a target pulse");
    wait_once_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer timing");
endmodule
bind udp_dma_ctrl udp_dma_ctrl_monitor udp_dma_ctrl_monitor_inst (.i_clk, .i_rst,
    .i_device_mode, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_waitrequest, .o_phy_suspend, .o_fifo_sel, .o_fifo_rd,
    .o_fifo_flush, .o_mem_req, .o_mem_write, .o_mem_addr, .o_mem_seq,
    .o_mem_undef_burst, .o_mem_hprot, .i_mem_ready);

//--- bench/udp_dma_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module udp_dma_ctrl_tb;
    import udp_pkg::*;
    logic i_clk = 0, i_rst = 1, i_device_mode = 1, i_avs_read = 0, i_avs_write = 0;
    logic [ADDR_W-1:0] i_avs_address = '0;
    logic [31:0] i_avs_writedata = '0, o_avs_readdata, i_fifo_rdata, o_fifo_wdata, o_mem_addr;
    logic [31:0] o_mem_wdata, i_mem_rdata, pdat = '0, rdv;
    logic [3:0] i_avs_byteenable = 4'hf, o_mem_hprot;
    logic o_avs_waitrequest, o_phy_suspend, o_fifo_rd, i_fifo_valid, o_fifo_wr, i_fifo_space;
    logic o_mem_req, o_mem_write, o_mem_seq, o_mem_undef_burst, i_mem_ready, i_mem_err;
    logic [FIFO_N-1:0] o_fifo_sel, o_fifo_flush;
    logic [2:0] o_fifo_bytes, o_mem_bytes;
    logic [1:0] lat = 0;
    logic err_on = 0, push = 0;
    logic [4:0] depth = 5'h10;
    logic [31:0] aq[$], dq[$], fq[$];
    logic [2:0] bq[$], fbq[$];
    int errors = 0, checked = 0, cyc = 0, fl_n = 0;
    udp_dma_ctrl udp_dma_ctrl_inst (.i_clk, .i_rst, .i_device_mode, .i_avs_address,
        .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
        .o_avs_waitrequest, .o_phy_suspend, .o_fifo_sel, .o_fifo_rd, .i_fifo_valid,
        .i_fifo_rdata, .o_fifo_wr, .i_fifo_space, .o_fifo_wdata, .o_fifo_bytes,
        .o_fifo_flush, .o_mem_req, .o_mem_write, .o_mem_addr, .o_mem_wdata, .o_mem_bytes,
        .o_mem_seq, .o_mem_undef_burst, .o_mem_hprot, .i_mem_ready, .i_mem_err, .i_mem_rdata);
    udp_far_model udp_far_model_inst (.i_clk, .i_mem_req(o_mem_req), .i_mem_addr(o_mem_addr),
        .i_fifo_rd(o_fifo_rd), .i_fifo_wr(o_fifo_wr), .i_fifo_wdata(o_fifo_wdata),
        .i_fifo_flush(o_fifo_flush), .i_lat(lat), .i_err_on(err_on), .i_depth(depth),
        .i_push(push), .i_push_data(pdat), .o_mem_ready(i_mem_ready), .o_mem_err(i_mem_err),
        .o_mem_rdata(i_mem_rdata), .o_fifo_valid(i_fifo_valid), .o_fifo_rdata(i_fifo_rdata),
        .o_fifo_space(i_fifo_space));
    always #5 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (o_mem_req && i_mem_ready) begin
            aq.push_back(o_mem_addr);
            bq.push_back(o_mem_bytes);
            dq.push_back(o_mem_wdata);
        end
        if (o_fifo_wr) begin
            fq.push_back(o_fifo_wdata);
            fbq.push_back(o_fifo_bytes);
        end
        if (o_fifo_flush != 5'h00) fl_n++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_address <= a;
        i_avs_writedata <= d;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        rdv = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wdone();
        repeat (100) begin
            bus(0, OFS_STATUS, 0);
            if (rdv[B_BUSY] === 1'b0) break;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(0, OFS_PARAM1, 0);
        `CHK("param reset", 32'h2600_0000, rdv)
        bus(1, OFS_PARAM1, 32'ha600_0000);
        bus(0, OFS_STATUS, 0);
        `CHK("suspend", 1'b1, o_phy_suspend)
        i_device_mode <= 1'b0;
        bus(0, OFS_STATUS, 0);
        `CHK("suspend gated", 1'b0, o_phy_suspend)
        i_device_mode <= 1'b1;
        bus(1, OFS_TARGET, 32'h0000_0001);
        for (int k = 0; k < 5; k++) begin
            push <= 1'b1;
            pdat <= 32'ha000_0000 + k;
            @(posedge i_clk);
        end
        push <= 1'b0;
        `CHK("fifo select", 5'h01, o_fifo_sel)
        lat <= 2'd2;
        bus(1, OFS_MEMPTR, 32'h0000_0040);
        // five beats in short-burst mode so the four-beat cap is crossed
        bus(1, OFS_PARAM1, 32'h1400_1201);
        wdone();
        `CHK("done", 4'b0010, rdv[3:0])
        `CHK("hprot", 4'b1010, o_mem_hprot)
        `CHK("burst", 1'b0, o_mem_undef_burst)
        for (int k = 0; k < 5; k++) begin
            `CHK("addr", 32'h40 + 4 * k, aq[k])
            `CHK("mem data", 32'ha000_0000 + k, dq[k])
            `CHK("bytes", (k == 4) ? 3'd2 : 3'd4, bq[k])
        end
        bus(1, OFS_STATUS, 32'h0000_000f);
        aq.delete();
        bus(1, OFS_TARGET, 32'h0000_0010);
        bus(1, OFS_MEMPTR, 32'h0000_0080);
        bus(1, OFS_PARAM1, 32'h2600_0807);
        wdone();
        for (int k = 0; k < 2; k++) begin
            `CHK("io addr", 32'h0000_0080, aq[k])
            `CHK("fifo data", 32'hc0de_0020, fq[k])
            `CHK("fifo bytes", 3'd4, fbq[k])
        end
        bus(1, OFS_STATUS, 32'h0000_000f);
        // no fifo space: the engine parks after its memory read, where abort may act
        depth <= 5'h00;
        lat <= 2'd0;
        for (int f = 0; f < 2; f++) begin
            fl_n = 0;
            bus(1, OFS_PARAM1, 32'h2600_0803);
            i_device_mode <= 1'b0;
            bus(1, OFS_PARAM1, 32'h2600_080a);
            bus(0, OFS_PARAM1, 0);
            `CHK("abort gated", 1'b1, rdv[B_START])
            i_device_mode <= 1'b1;
            bus(1, OFS_PARAM1, 32'h2600_080a | (f << B_FLUSH));
            wdone();
            bus(0, OFS_PARAM1, 0);
            `CHK("abort clear", 4'b0010, rdv[3:0])
            bus(0, OFS_STATUS, 0);
            `CHK("aborted", 1'b1, rdv[B_ABORTED])
            `CHK("fifo kept", f == 0, i_fifo_valid)
            `CHK("flushes", f, fl_n)
            bus(1, OFS_STATUS, 32'h0000_000f);
        end
        bus(1, OFS_PARAM1, 32'h2600_0008);
        bus(0, OFS_STATUS, 0);
        `CHK("idle abort", 1'b0, rdv[B_ABORTED])
        err_on <= 1'b1;
        bus(1, OFS_PARAM1, 32'h2600_0403);
        wdone();
        `CHK("error", 4'b0100, rdv[3:0])
        complete_run();
    end
endmodule

//--- bench/udp_far_model.sv
`timescale 1ns/1ps
module udp_far_model (
    input wire logic i_clk,
    input wire logic i_mem_req,
    input wire logic [31:0] i_mem_addr,
    input wire logic i_fifo_rd,
    input wire logic i_fifo_wr,
    input wire logic [31:0] i_fifo_wdata,
    input wire logic [4:0] i_fifo_flush,
    input wire logic [1:0] i_lat,
    input wire logic i_err_on,
    input wire logic [4:0] i_depth,
    input wire logic i_push,
    input wire logic [31:0] i_push_data,
    output logic o_mem_ready = 1'b0,
    output logic o_mem_err = 1'b0,
    output logic [31:0] o_mem_rdata = 32'h0000_0000,
    output logic o_fifo_valid,
    output logic [31:0] o_fifo_rdata,
    output logic o_fifo_space
);
    logic [31:0] fq [16];
    logic [4:0] wp = 5'h00;
    logic [4:0] rp = 5'h00;
    logic [1:0] cnt = 2'h0;
    assign o_fifo_valid = wp != rp;
    // an empty queue shows the inverted stale word, never a usable head
    assign o_fifo_rdata = o_fifo_valid ? fq[rp[3:0]] : ~fq[rp[3:0]];
    assign o_fifo_space = (wp - rp) < i_depth;
    always @(posedge i_clk) begin
        if (i_fifo_flush != 5'h00) begin
            rp <= wp;
        end else if (i_fifo_rd) begin
            rp <= rp + 5'h01;
        end
        if (i_push || i_fifo_wr) begin
            fq[wp[3:0]] <= i_push ? i_push_data : i_fifo_wdata;
            wp <= wp + 5'h01;
        end
    end
    // memory answers after i_lat idle cycles; read data is c0de over address bits 17:2
    always @(posedge i_clk) begin
        if (i_mem_req && !o_mem_ready && cnt == i_lat) begin
            o_mem_ready <= 1'b1;
            o_mem_err <= i_err_on;
            o_mem_rdata <= {16'hc0de, i_mem_addr[17:2]};
            cnt <= 2'h0;
        end else begin
            o_mem_ready <= 1'b0;
            o_mem_err <= 1'b0;
            o_mem_rdata <= ~o_mem_rdata;
            cnt <= (i_mem_req && !o_mem_ready) ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule

//--- hdl/udp_dma_ctrl.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module udp_dma_ctrl
    import udp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_device_mode,
    // register bus
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // transceiver
    output logic o_phy_suspend,
    // fifo side, muxed outside by o_fifo_sel
    output logic [FIFO_N-1:0] o_fifo_sel,
    output logic o_fifo_rd,
    input wire logic i_fifo_valid,
    input wire logic [31:0] i_fifo_rdata,
    output logic o_fifo_wr,
    input wire logic i_fifo_space,
    output logic [31:0] o_fifo_wdata,
    output logic [2:0] o_fifo_bytes,
    output logic [FIFO_N-1:0] o_fifo_flush,
    // memory initiator
    output logic o_mem_req,
    output logic o_mem_write,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    output logic [2:0] o_mem_bytes,
    output logic o_mem_seq,
    output logic o_mem_undef_burst,
    output logic [3:0] o_mem_hprot,
    input wire logic i_mem_ready,
    input wire logic i_mem_err,
    input wire logic [31:0] i_mem_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic suspend_r;
    logic burst_undef_r;
    logic [3:0] hprot_r;
    logic [LEN_W-1:0] len_r;
    logic flush_r;
    logic abort_r;
    logic io_r;
    logic dir_r;
    logic start_r;
    logic [31:0] memptr_r;
    logic [FIFO_N-1:0] target_r;
    logic done_r;
    logic err_r;
    logic aborted_r;

    logic wait_r;
    logic [31:0] rdata_r;
    logic acc;
    logic wr_acc;
    logic [31:0] wmask;
    logic [31:0] param1_rd;
    logic [31:0] status_rd;

    udp_state_t state_r;
    logic [LEN_W-1:0] rem_r;
    logic [31:0] addr_r;
    logic [31:0] data_r;
    logic [1:0] beat_r;
    logic beat_any_r;
    logic [2:0] beat_bytes;
    logic stop_now;
    logic finish;
    logic fail;
    logic last_beat;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, request taken when waitrequest is low

    assign acc = (i_avs_read | i_avs_write) & ~wait_r;
    assign wr_acc = i_avs_write & ~wait_r;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[8*i +: 8] = {8{i_avs_byteenable[i]}};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wait_r <= 1'b1;
        end else if ((i_avs_read | i_avs_write) && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    assign param1_rd = {suspend_r, 1'b0, burst_undef_r, hprot_r, len_r, 3'h0,
                        flush_r, abort_r, io_r, dir_r, start_r};
    assign status_rd = {28'h000_0000, aborted_r, err_r, done_r, start_r};

    // read data is registered on the same edge that drops waitrequest
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_avs_read && wait_r) begin
            case (i_avs_address)
                OFS_TARGET: rdata_r <= {27'h000_0000, target_r};
                OFS_PARAM1: rdata_r <= param1_rd;
                OFS_MEMPTR: rdata_r <= memptr_r;
                OFS_STATUS: rdata_r <= status_rd;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // parameter register

    logic [31:0] p1_new;
    assign p1_new = (param1_rd & ~wmask) | (i_avs_writedata & wmask);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            suspend_r <= RST_SUSPEND;
            burst_undef_r <= RST_BURST;
            hprot_r <= RST_HPROT;
            len_r <= RST_LEN;
            io_r <= 1'b0;
            dir_r <= 1'b0;
        end else if (wr_acc && i_avs_address == OFS_PARAM1) begin
            // suspend is a plain system-clock flop, not crossed to the phy clock
            suspend_r <= p1_new[B_SUSPEND];
            burst_undef_r <= p1_new[B_BURST];
            hprot_r <= p1_new[B_HPROT_LO +: 4];
            len_r <= p1_new[B_LEN_LO +: LEN_W];
            io_r <= p1_new[B_IO];
            dir_r <= p1_new[B_DIR];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            memptr_r <= RST_MEMPTR;
            target_r <= RST_TARGET;
        end else if (wr_acc) begin
            if (i_avs_address == OFS_MEMPTR) begin
                memptr_r <= (memptr_r & ~wmask) | (i_avs_writedata & wmask);
            end
            if (i_avs_address == OFS_TARGET && i_avs_byteenable[0]) begin
                target_r <= i_avs_writedata[FIFO_N-1:0];
            end
        end
    end

    // start: software may only set it, hardware alone clears it
    logic sw_start;
    logic sw_abort;
    assign sw_start = wr_acc && i_avs_address == OFS_PARAM1 && i_avs_byteenable[0]
                      && i_avs_writedata[B_START] && !start_r;
    // abort counts only during an active transfer in device mode
    assign sw_abort = wr_acc && i_avs_address == OFS_PARAM1 && i_avs_byteenable[0]
                      && i_avs_writedata[B_ABORT] && start_r
                      && i_device_mode;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            start_r <= 1'b0;
        end else if (finish || fail || stop_now) begin
            start_r <= 1'b0;
        end else if (sw_start) begin
            start_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            abort_r <= 1'b0;
            flush_r <= 1'b0;
        end else if (stop_now) begin
            abort_r <= 1'b0;
            flush_r <= 1'b0;
        end else if (sw_abort && !abort_r) begin
            abort_r <= 1'b1;
            flush_r <= i_avs_writedata[B_FLUSH];
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
            aborted_r <= 1'b0;
        end else begin
            if (finish) begin
                done_r <= 1'b1;
            end else if (wr_acc && i_avs_address == OFS_STATUS && i_avs_byteenable[0]
                         && i_avs_writedata[B_DONE]) begin
                done_r <= 1'b0;
            end
            if (fail) begin
                err_r <= 1'b1;
            end else if (wr_acc && i_avs_address == OFS_STATUS && i_avs_byteenable[0]
                         && i_avs_writedata[B_ERR]) begin
                err_r <= 1'b0;
            end
            if (stop_now) begin
                aborted_r <= 1'b1;
            end else if (wr_acc && i_avs_address == OFS_STATUS && i_avs_byteenable[0]
                         && i_avs_writedata[B_ABORTED]) begin
                aborted_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer engine, one word per beat

    assign beat_bytes = (rem_r < LEN_W'(WORD_BYTES)) ? rem_r[2:0] : WORD_BYTES;
    assign last_beat = rem_r <= LEN_W'(WORD_BYTES);
    // abort only between memory accesses so no bus transfer is cut short
    assign stop_now = abort_r && state_r != UDP_MEM;
    assign fail = state_r == UDP_MEM && i_mem_ready && i_mem_err;
    assign finish = (state_r == UDP_MEM && i_mem_ready && !i_mem_err && !dir_r && last_beat)
                    || (state_r == UDP_FIFO && dir_r && i_fifo_space && last_beat
                        && !abort_r);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= UDP_IDLE;
            rem_r <= RST_LEN;
            addr_r <= RST_MEMPTR;
            data_r <= 32'h0000_0000;
        end else begin
            case (state_r)
                UDP_IDLE: begin
                    if (start_r && !abort_r) begin
                        rem_r <= len_r;
                        addr_r <= memptr_r;
                        state_r <= dir_r ? UDP_MEM : UDP_FIFO;
                    end
                end
                UDP_FIFO: begin
                    if (abort_r) begin
                        state_r <= UDP_IDLE;
                    end else if (!dir_r && i_fifo_valid) begin
                        data_r <= i_fifo_rdata;
                        state_r <= UDP_MEM;
                    end else if (dir_r && i_fifo_space) begin
                        rem_r <= rem_r - LEN_W'(beat_bytes);
                        state_r <= last_beat ? UDP_IDLE : UDP_MEM;
                    end
                end
                UDP_MEM: begin
                    if (i_mem_ready) begin
                        if (i_mem_err) begin
                            state_r <= UDP_IDLE;
                        end else begin
                            if (dir_r) begin
                                data_r <= i_mem_rdata;
                                state_r <= UDP_FIFO;
                            end else begin
                                rem_r <= rem_r - LEN_W'(beat_bytes);
                                state_r <= last_beat ? UDP_IDLE : UDP_FIFO;
                            end
                            if (!io_r) begin
                                addr_r <= addr_r + 32'h0000_0004;
                            end
                        end
                    end
                end
                default: state_r <= UDP_IDLE;
            endcase
        end
    end

    // beats of the current burst; short mode restarts a burst every four beats
    always_ff @(posedge i_clk) begin
        if (i_rst || state_r == UDP_IDLE) begin
            beat_r <= 2'h0;
            beat_any_r <= 1'b0;
        end else if (state_r == UDP_MEM && i_mem_ready) begin
            beat_r <= beat_r + 2'h1;
            beat_any_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    logic mem_go;
    assign mem_go = (state_r == UDP_FIFO && !dir_r && i_fifo_valid && !abort_r)
                    || (state_r == UDP_FIFO && dir_r && i_fifo_space && !last_beat
                        && !abort_r)
                    || (state_r == UDP_IDLE && start_r && !abort_r && dir_r)
                    || (state_r == UDP_MEM && !i_mem_ready);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mem_req <= 1'b0;
            o_mem_write <= 1'b0;
            o_mem_addr <= 32'h0000_0000;
            o_mem_wdata <= 32'h0000_0000;
            o_mem_bytes <= 3'h0;
            o_mem_seq <= 1'b0;
        end else begin
            o_mem_req <= mem_go;
            o_mem_write <= !dir_r;
            o_mem_addr <= (state_r == UDP_IDLE) ? memptr_r : addr_r;
            o_mem_wdata <= (state_r == UDP_FIFO) ? i_fifo_rdata : o_mem_wdata;
            o_mem_bytes <= (state_r == UDP_IDLE)
                           ? ((len_r < LEN_W'(WORD_BYTES)) ? len_r[2:0] : WORD_BYTES)
                           : beat_bytes;
            // seq marks continuation; undefined bursts never break, short ones wrap at four
            o_mem_seq <= (state_r != UDP_IDLE)
                         && (burst_undef_r ? beat_any_r : (beat_r != 2'h0));
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mem_undef_burst <= RST_BURST;
            o_mem_hprot <= RST_HPROT;
        end else begin
            o_mem_undef_burst <= burst_undef_r;
            o_mem_hprot <= hprot_r;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_fifo_rd <= 1'b0;
            o_fifo_wr <= 1'b0;
            o_fifo_wdata <= 32'h0000_0000;
            o_fifo_bytes <= 3'h0;
            o_fifo_sel <= RST_TARGET;
            o_fifo_flush <= RST_TARGET;
        end else begin
            o_fifo_rd <= state_r == UDP_FIFO && !dir_r && i_fifo_valid && !abort_r;
            o_fifo_wr <= state_r == UDP_FIFO && dir_r && i_fifo_space && !abort_r;
            o_fifo_wdata <= data_r;
            o_fifo_bytes <= beat_bytes;
            o_fifo_sel <= target_r;
            // flush pulse only after the stop, only if asked together with abort
            o_fifo_flush <= (stop_now && flush_r) ? target_r : RST_TARGET;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_phy_suspend <= RST_SUSPEND;
        end else begin
            o_phy_suspend <= suspend_r && i_device_mode;
        end
    end

    assign o_avs_readdata = rdata_r;
    assign o_avs_waitrequest = wait_r;

endmodule

//--- hdl/udp_pkg.sv
// Function
// - suspend bit, reset zero, drives the transceiver into minimal-power suspend
// - suspend acts only in device mode and lives in the system clock domain
// - burst style bit resets to one; undefined bursts, else at most four beats
// - four-bit field, reset 0011, drives the bus protection attribute of transfers
// - transfer byte count gives total bytes of one operation, resets to zero
// - flush-on-cancel written with abort empties the target FIFO after the abort
// - abort during an active transfer stops it; hardware clears abort when stopped
// - abort takes effect only in device mode
// - abort written while start is zero has no effect
// - I/O-to-I/O mode keeps the memory address fixed for every beat
// - start set after setup; only hardware clears it, on completion, error or abort
// - direction zero moves FIFO to memory, one moves memory to FIFO
package udp_pkg;

    localparam int ADDR_W = 12;
    localparam int LEN_W = 17;
    localparam int FIFO_N = 5;

    localparam logic [ADDR_W-1:0] OFS_TARGET = 12'h1c0;
    localparam logic [ADDR_W-1:0] OFS_PARAM1 = 12'h1c8;
    localparam logic [ADDR_W-1:0] OFS_MEMPTR = 12'h1cc;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h1e0;

    // parameter one layout
    localparam int B_SUSPEND = 31;
    localparam int B_BURST = 29;
    localparam int B_HPROT_LO = 25;
    localparam int B_LEN_LO = 8;
    localparam int B_FLUSH = 4;
    localparam int B_ABORT = 3;
    localparam int B_IO = 2;
    localparam int B_DIR = 1;
    localparam int B_START = 0;

    // status layout
    localparam int B_BUSY = 0;
    localparam int B_DONE = 1;
    localparam int B_ERR = 2;
    localparam int B_ABORTED = 3;

    localparam logic RST_SUSPEND = 1'b0;
    localparam logic RST_BURST = 1'b1;
    localparam logic [3:0] RST_HPROT = 4'b0011;
    localparam logic [LEN_W-1:0] RST_LEN = 17'h0_0000;
    localparam logic [31:0] RST_MEMPTR = 32'h0000_0000;
    localparam logic [FIFO_N-1:0] RST_TARGET = 5'h00;

    localparam logic [1:0] SHORT_BURST_LAST = 2'h3;
    localparam logic [2:0] WORD_BYTES = 3'h4;

    typedef enum logic [1:0] {
        UDP_IDLE = 2'b00,
        UDP_FIFO = 2'b01,
        UDP_MEM = 2'b10
    } udp_state_t;

endpackage
